// File: logic/burst_label_pkg.sv
// shared constants and types for the burst source labelling block
package burst_label_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] GROUP_LOGON_OFFSET = 8'h04;
  localparam logic [7:0] HOST_ID_HI_OFFSET = 8'h08;
  localparam logic [7:0] HOST_ID_LO_OFFSET = 8'h0c;
  localparam logic [7:0] DEF_SVN_DA_OFFSET = 8'h10;
  localparam logic [7:0] DEF_SVN_RA_OFFSET = 8'h14;
  localparam logic [7:0] STATUS_OFFSET = 8'h18;

  // control register fields
  localparam int CTRL_TRAFFIC_RA_BIT = 0;
  localparam int CTRL_FORCE_TAG_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // status register fields
  localparam int STATUS_REFUSED_MIX_BIT = 0;
  localparam int STATUS_REFUSED_TRAFFIC_BIT = 1;
  localparam int STATUS_BUSY_BIT = 2;
  localparam int STATUS_COUNT_LSB = 16;

  // identity field widths and reset values
  localparam int GROUP_WIDTH = 8;
  localparam int LOGON_WIDTH = 16;
  localparam int HOST_ID_WIDTH = 48;
  localparam int SVN_WIDTH = 16;
  localparam logic [47:0] HOST_ID_RESET = 48'h0000_0000_0000;
  localparam logic [23:0] GROUP_LOGON_RESET = 24'h00_0000;
  localparam logic [15:0] DEF_SVN_RESET = 16'h0000;

  // label lengths in bytes
  localparam logic [3:0] LOGON_LABEL_LEN = 4'h6;
  localparam logic [3:0] SOURCE_LABEL_LEN = 4'h3;
  localparam logic [3:0] NO_LABEL_LEN = 4'h0;
  localparam logic [3:0] SVN_TAG_LEN = 4'h1;
  localparam int LABEL_BUF_BYTES = 7;

  // output buffer
  localparam int FIFO_DEPTH = 32;

  typedef enum logic [1:0] {BURST_LOGON, BURST_CONTROL, BURST_TRAFFIC} burstKind_type;
  typedef enum logic {ACCESS_DEDICATED, ACCESS_RANDOM} accessKind_type;

  // one burst (or one segment of an sdu) to be labelled
  typedef struct packed {
    burstKind_type burstKind;
    accessKind_type accessKind;
    logic [SVN_WIDTH-1:0] virtual_network_number;
    logic alLabelNeeded;
    logic descriptorAllowsRa;
    logic sduFirst;
    logic sduLast;
    logic daPlanned;
  } request_type;

  // one emitted label byte
  typedef struct packed {
    logic alTag;
    logic last;
    logic [7:0] data;
  } labelByte_type;

endpackage

// File: logic/burst_source_labeling.sv
// payload label and adaptation unit tag builder with apb registers and output fifo
//
// Operation
// - logon random access uses 48-bit host identity
// - control source is group then logon identifier
// - no address for control in dedicated slots
// - each unit carries its submitter's network number
// - tag network number when not the default
// - narrow tag keeps low bits, msb first
// - default number may drop unneeded tag
// - one-byte unit label carries network number
// - non-logon contention bursts carry three-byte source label
// - destination address never inserted, gateway implied
// - dedicated resources omit source and destination
// - unit and packet addresses inherited, omitted
// - map units to any compatible opportunity
// - no random access once sdu uses dedicated
// - no traffic in contention unless permitted
// - identifiers sent most significant byte first
`timescale 1ns/1ps

module label_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] count_q;
  wire logic doWrite = inValid && inReady;
  wire logic doRead = outValid && outReady;

  // full and empty come straight from the occupancy count
  assign inReady = (count_q != (AW + 1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData = mem[rdPtr_q];

  // storage has no reset; only pointers and count need a defined state
  always_ff @(posedge clk)
  begin
    if (doWrite)
      mem[wrPtr_q] <= inData;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (doWrite)
        wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
      if (doRead)
        rdPtr_q <= (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
      count_q <= count_q + (AW + 1)'(doWrite) - (AW + 1)'(doRead);
    end
  end
endmodule

module burst_source_labeling #(
  parameter int FIFO_WORDS = burst_label_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reqValid,
  input wire burst_label_pkg::request_type req,
  output logic reqReady,
  output logic infoValid,
  output logic [3:0] labelLen,
  output logic svnTagged,
  output logic refused,
  output logic outValid,
  output burst_label_pkg::labelByte_type outByte,
  input wire logic outReady
);
  typedef enum logic {IDLE, EMIT} state_type;

  localparam int BUF_BITS = 8 * burst_label_pkg::LABEL_BUF_BYTES;
  localparam int BYTE_W = $bits(burst_label_pkg::labelByte_type);

  // software-visible state
  logic [1:0] ctrl_q;
  logic [23:0] groupLogon_q;
  logic [47:0] hostId_q;
  logic [15:0] defSvnDa_q;
  logic [15:0] defSvnRa_q;
  logic [1:0] sticky_q;
  logic [15:0] burstCount_q;

  // builder state
  state_type state_q;
  logic [BUF_BITS-1:0] buf_q;
  logic [3:0] remain_q;
  logic [3:0] paylLeft_q;
  logic sduDa_q;

  // output port flops
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic reqReady_q;
  logic infoValid_q;
  logic [3:0] labelLen_q;
  logic svnTagged_q;
  logic refused_q;
  logic outValid_q;
  burst_label_pkg::labelByte_type outByte_q;

  // apb decode; the answer comes one cycle into the access phase
  wire logic apbAccess = psel && penable && !pready_q;
  wire logic apbWrite = apbAccess && pwrite;
  wire logic hitCtrl = (paddr == burst_label_pkg::CTRL_OFFSET);
  wire logic hitGroup = (paddr == burst_label_pkg::GROUP_LOGON_OFFSET);
  wire logic hitIdHi = (paddr == burst_label_pkg::HOST_ID_HI_OFFSET);
  wire logic hitIdLo = (paddr == burst_label_pkg::HOST_ID_LO_OFFSET);
  wire logic hitSvnDa = (paddr == burst_label_pkg::DEF_SVN_DA_OFFSET);
  wire logic hitSvnRa = (paddr == burst_label_pkg::DEF_SVN_RA_OFFSET);
  wire logic hitStatus = (paddr == burst_label_pkg::STATUS_OFFSET);
  wire logic hitAny = hitCtrl | hitGroup | hitIdHi | hitIdLo | hitSvnDa | hitSvnRa | hitStatus;

  wire logic [31:0] statusWord = {burstCount_q, 13'h0000, (state_q == EMIT), sticky_q};
  wire logic [31:0] readMux =
    hitCtrl ? {30'h0000_0000, ctrl_q} :
    hitGroup ? {8'h00, groupLogon_q} :
    hitIdHi ? {16'h0000, hostId_q[47:32]} :
    hitIdLo ? hostId_q[31:0] :
    hitSvnDa ? {16'h0000, defSvnDa_q} :
    hitSvnRa ? {16'h0000, defSvnRa_q} :
    hitStatus ? statusWord : 32'h0000_0000;

  // request evaluation
  wire logic accept = reqValid && reqReady_q;
  wire logic isRandom = (req.accessKind == burst_label_pkg::ACCESS_RANDOM);
  wire logic isTraffic = (req.burstKind == burst_label_pkg::BURST_TRAFFIC);
  wire logic isLogon = (req.burstKind == burst_label_pkg::BURST_LOGON);
  // dedicated use of this sdu, past, present or still to come
  wire logic daSeen = (req.sduFirst ? 1'b0 : sduDa_q) || !isRandom || req.daPlanned;
  wire logic refuseMix = isRandom && daSeen;
  wire logic refuseTraffic = isRandom && isTraffic && !req.descriptorAllowsRa
    && !ctrl_q[burst_label_pkg::CTRL_TRAFFIC_RA_BIT];
  wire logic refuseNow = refuseMix || refuseTraffic;

  // payload label: logon shows host identity, other contention bursts group then logon
  // identifier, dedicated bursts nothing since the plan table already names us
  wire logic [3:0] paylLen =
    !isRandom ? burst_label_pkg::NO_LABEL_LEN :
    isLogon ? burst_label_pkg::LOGON_LABEL_LEN :
    burst_label_pkg::SOURCE_LABEL_LEN;
  // left aligned so the first byte out is the most significant one; no destination
  // field exists at all because the gateway is the implied receiver
  wire logic [BUF_BITS-1:0] paylBits =
    !isRandom ? '0 :
    isLogon ? {hostId_q, 8'h00} :
    {groupLogon_q, 32'h0000_0000};

  // unit tag: the number of the submitting entity, default per access context
  wire logic [15:0] defSvn = isRandom ? defSvnRa_q : defSvnDa_q;
  wire logic needTag = isTraffic && ((req.virtual_network_number != defSvn) || req.alLabelNeeded
    || ctrl_q[burst_label_pkg::CTRL_FORCE_TAG_BIT]);
  // only the low byte fits the one-byte label, kept msb first
  wire logic [7:0] tagByte = req.virtual_network_number[7:0];
  wire logic [BUF_BITS-1:0] tagBits =
    {tagByte, 48'h0000_0000_0000} >> (7'(paylLen) * 7'd8);
  wire logic [3:0] totalLen = paylLen + (needTag ? burst_label_pkg::SVN_TAG_LEN : 4'h0);

  // fifo feed: one byte per cycle while emitting, stalled by a full fifo
  wire logic fifoInReady;
  wire logic fifoOutValid;
  wire logic [BYTE_W-1:0] fifoOutData;
  wire burst_label_pkg::labelByte_type emitByte = '{
    alTag: (paylLeft_q == 4'h0),
    last: (remain_q == 4'h1),
    data: buf_q[BUF_BITS-1 -: 8]
  };
  wire logic emitting = (state_q == EMIT);
  wire logic pushByte = emitting && fifoInReady;
  // output stage refills when empty or when its byte is being taken
  wire logic popByte = fifoOutValid && (!outValid_q || outReady);

  label_fifo #(
    .WIDTH(BYTE_W),
    .DEPTH(FIFO_WORDS)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .inValid(emitting),
    .inReady(fifoInReady),
    .inData(emitByte),
    .outValid(fifoOutValid),
    .outReady(popByte),
    .outData(fifoOutData)
  );

  // apb answer registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= apbAccess;
      pslverr_q <= apbAccess && !hitAny; // unmapped address answers with an error
      prdata_q <= (apbAccess && !pwrite) ? readMux : 32'h0000_0000;
    end
  end

  // software-written configuration; identity is loaded from non-volatile store by software
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_q <= burst_label_pkg::CTRL_RESET;
      groupLogon_q <= burst_label_pkg::GROUP_LOGON_RESET;
      hostId_q <= burst_label_pkg::HOST_ID_RESET;
      defSvnDa_q <= burst_label_pkg::DEF_SVN_RESET;
      defSvnRa_q <= burst_label_pkg::DEF_SVN_RESET;
    end
    else if (apbWrite)
    begin
      if (hitCtrl)
        ctrl_q <= pwdata[1:0];
      if (hitGroup)
        groupLogon_q <= pwdata[23:0];
      if (hitIdHi)
        hostId_q[47:32] <= pwdata[15:0];
      if (hitIdLo)
        hostId_q[31:0] <= pwdata[31:0];
      if (hitSvnDa)
        defSvnDa_q <= pwdata[15:0];
      if (hitSvnRa)
        defSvnRa_q <= pwdata[15:0];
    end
  end

  // sticky refusal flags: write one to clear, a new refusal in the same cycle wins
  wire logic [1:0] stickyClr = (apbWrite && hitStatus) ? pwdata[1:0] : 2'b00;
  wire logic [1:0] stickySet = accept ? {refuseTraffic, refuseMix} : 2'b00;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sticky_q <= 2'b00;
      burstCount_q <= 16'h0000;
      sduDa_q <= 1'b0;
    end
    else
    begin
      sticky_q <= (sticky_q & ~stickyClr) | stickySet;
      if (accept && !refuseNow)
        burstCount_q <= burstCount_q + 16'h0001;
      if (accept)
        sduDa_q <= req.sduLast ? 1'b0 : daSeen;
    end
  end

  // builder: take a request, then shift its label bytes into the fifo
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= IDLE;
      buf_q <= '0;
      remain_q <= 4'h0;
      paylLeft_q <= 4'h0;
      reqReady_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        IDLE:
        begin
          reqReady_q <= 1'b1;
          if (accept && !refuseNow && totalLen != 4'h0)
          begin
            state_q <= EMIT;
            buf_q <= paylBits | (needTag ? tagBits : '0);
            remain_q <= totalLen;
            paylLeft_q <= paylLen;
            reqReady_q <= 1'b0;
          end
        end
        EMIT:
        begin
          if (pushByte)
          begin
            buf_q <= buf_q << 8;
            remain_q <= remain_q - 4'h1;
            if (paylLeft_q != 4'h0)
              paylLeft_q <= paylLeft_q - 4'h1;
            if (remain_q == 4'h1)
            begin
              state_q <= IDLE;
              reqReady_q <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  // per-burst summary, one-cycle pulse at acceptance
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      infoValid_q <= 1'b0;
      labelLen_q <= 4'h0;
      svnTagged_q <= 1'b0;
      refused_q <= 1'b0;
    end
    else
    begin
      infoValid_q <= accept;
      refused_q <= accept && refuseNow;
      if (accept)
      begin
        labelLen_q <= refuseNow ? 4'h0 : paylLen;
        svnTagged_q <= !refuseNow && needTag;
      end
    end
  end

  // output register stage so the byte stream leaves straight from flops
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      outValid_q <= 1'b0;
      outByte_q <= '0;
    end
    else if (!outValid_q || outReady)
    begin
      outValid_q <= fifoOutValid;
      if (fifoOutValid)
        outByte_q <= fifoOutData;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign reqReady = reqReady_q;
  assign infoValid = infoValid_q;
  assign labelLen = labelLen_q;
  assign svnTagged = svnTagged_q;
  assign refused = refused_q;
  assign outValid = outValid_q;
  assign outByte = outByte_q;
endmodule

// File: tb/burst_source_labeling_checker.sv
// port assertions for the burst source labelling block
`timescale 1ns/1ps
module burst_source_labeling_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic reqValid,
  input wire burst_label_pkg::request_type req,
  input wire logic reqReady,
  input wire logic infoValid,
  input wire logic [3:0] labelLen,
  input wire logic svnTagged,
  input wire logic refused,
  input wire logic outValid,
  input wire burst_label_pkg::labelByte_type outByte,
  input wire logic outReady
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // request kinds as seen on the edge that takes them
  sequence s_take;
    reqValid && reqReady;
  endsequence
  // contention bursts that cannot be refused: first segment, no dedicated use planned
  sequence s_logonRa;
    reqValid && reqReady && req.burstKind == burst_label_pkg::BURST_LOGON && req.accessKind
      && req.sduFirst && !req.daPlanned;
  endsequence
  sequence s_ctrlRa;
    reqValid && reqReady && req.burstKind == burst_label_pkg::BURST_CONTROL && req.accessKind
      && req.sduFirst && !req.daPlanned;
  endsequence
  sequence s_ded;
    reqValid && reqReady && !req.accessKind;
  endsequence
  sequence s_mixRa;
    reqValid && reqReady && req.accessKind && req.daPlanned;
  endsequence
  chk_apb_answer: assert property (psel && penable && !pready |=> pready)
    else $error("apb access not answered after one cycle");
  chk_apb_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  chk_info_after: assert property (s_take |=> infoValid)
    else $error("no info pulse after a taken request");
  chk_logon_len: assert property (s_logonRa |=> labelLen == 4'h6 && !refused)
    else $error("logon label length wrong");
  chk_src_len: assert property (s_ctrlRa |=> labelLen == 4'h3 && !svnTagged)
    else $error("control source label length wrong");
  chk_ded_none: assert property (s_ded |=> labelLen == 4'h0)
    else $error("dedicated burst got a payload label");
  chk_mix_refuse: assert property (s_mixRa |=> refused && labelLen == 4'h0)
    else $error("random segment of a dedicated sdu not refused");
  chk_refuse_info: assert property (refused |-> infoValid)
    else $error("refusal without info pulse");
  chk_stall_hold: assert property (outValid && !outReady |=> outValid && $stable(outByte))
    else $error("stalled byte changed or dropped");
endmodule
bind burst_source_labeling burst_source_labeling_checker chk_i (.clk, .rst, .psel, .penable,
  .pready, .reqValid, .req, .reqReady, .infoValid, .labelLen, .svnTagged, .refused,
  .outValid, .outByte, .outReady);

// File: tb/burst_source_labeling_tb_top.sv
// self-checking bench for the burst source labelling block
`timescale 1ns/1ps
module burst_source_labeling_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, reqValid = 1'b0, stall = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, se, reqReady, infoValid, svnTagged, refused, outValid, outReady;
  logic [3:0] labelLen;
  logic [15:0] unitSvn;
  burst_label_pkg::request_type req = '0;
  burst_label_pkg::labelByte_type outByte;
  logic [9:0] expq[$];
  int err_count = 0;
  int compares = 0;
  always #12.5 clk = ~clk;
  burst_source_labeling dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reqValid(reqValid), .req(req), .reqReady(reqReady),
    .infoValid(infoValid), .labelLen(labelLen), .svnTagged(svnTagged), .refused(refused),
    .outValid(outValid), .outByte(outByte), .outReady(outReady));
  label_sink u_sink (.clk(clk), .rst(rst), .stall(stall), .defSvn(16'h0009),
    .outValid(outValid), .outByte(outByte), .outReady(outReady), .unitSvn(unitSvn));
  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is sampled high; only the watchdog ends a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // r packs kind, access, svn, then five flag bits; result read one edge after take
  task automatic send(input logic [23:0] r, input logic [3:0] l, input logic t, input logic f);
    @(posedge clk);
    req <= burst_label_pkg::request_type'(r);
    reqValid <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (reqReady !== 1'b1);
    reqValid <= 1'b0;
    @(posedge clk);
    check({infoValid, refused, svnTagged, labelLen}, {1'b1, f, t, l});
  endtask
  task automatic put(input logic [47:0] v, input int n, input logic fin);
    for (int i = n - 1; i >= 0; i--)
      expq.push_back({1'b0, fin && i == 0, v[i*8 +: 8]});
  endtask
  // waits a settling margin so that stray extra bytes are caught too
  task automatic drain(input string name);
    int n;
    n = 0;
    while ((u_sink.got.size() < expq.size() || n < 8) && n < 500)
    begin
      @(posedge clk);
      n++;
    end
    check(u_sink.got.size(), expq.size());
    while (expq.size() > 0 && u_sink.got.size() > 0)
      check(u_sink.got.pop_front(), expq.pop_front());
    expq.delete();
    $display("test %s done", name);
  endtask
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // main sequence: registers, then each burst kind, then buffer fill
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 8'h18, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h1c, 32'h0);
    check({se, rd}, {1'b1, 32'h0});
    apb(1'b1, 8'h04, 32'h005a1234);
    apb(1'b1, 8'h08, 32'h0000a1b2);
    apb(1'b1, 8'h0c, 32'hc3d4e5f6);
    apb(1'b1, 8'h10, 32'h00000003);
    apb(1'b1, 8'h14, 32'h00000009);
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h005a1234);
    send({2'h0, 1'b1, 16'h0000, 5'h06}, 4'h6, 1'b0, 1'b0);
    put(48'ha1b2c3d4e5f6, 6, 1'b1);
    drain("logon ra");
    send({2'h1, 1'b1, 16'h0000, 5'h06}, 4'h3, 1'b0, 1'b0);
    put(48'h5a1234, 3, 1'b1);
    drain("control ra");
    send({2'h1, 1'b0, 16'h0000, 5'h06}, 4'h0, 1'b0, 1'b0);
    drain("control da");
    send({2'h2, 1'b0, 16'h0003, 5'h06}, 4'h0, 1'b0, 1'b0);
    drain("traffic da default");
    send({2'h2, 1'b0, 16'h0105, 5'h06}, 4'h0, 1'b1, 1'b0);
    expq.push_back(10'h305);
    drain("traffic da tagged");
    check(unitSvn, 16'h0005);
    send({2'h2, 1'b1, 16'h0009, 5'h06}, 4'h0, 1'b0, 1'b1);
    drain("traffic ra refused");
    apb(1'b0, 8'h18, 32'h0);
    check(rd[1:0], 2'h2);
    apb(1'b1, 8'h18, 32'h00000003);
    apb(1'b0, 8'h18, 32'h0);
    check(rd[1:0], 2'h0);
    send({2'h2, 1'b0, 16'h0003, 5'h0c}, 4'h0, 1'b0, 1'b0);
    send({2'h2, 1'b1, 16'h0009, 5'h0a}, 4'h0, 1'b0, 1'b1);
    send({2'h1, 1'b1, 16'h0000, 5'h07}, 4'h0, 1'b0, 1'b1);
    drain("mixed access");
    apb(1'b0, 8'h18, 32'h0);
    check(rd[1:0], 2'h1);
    apb(1'b1, 8'h00, 32'h00000001);
    send({2'h2, 1'b1, 16'h0009, 5'h06}, 4'h3, 1'b0, 1'b0);
    put(48'h5a1234, 3, 1'b1);
    drain("traffic ra default");
    check(unitSvn, 16'h0009);
    send({2'h2, 1'b1, 16'h0207, 5'h06}, 4'h3, 1'b1, 1'b0);
    put(48'h5a1234, 3, 1'b0);
    expq.push_back(10'h307);
    drain("traffic ra tagged");
    check(unitSvn, 16'h0007);
    send({2'h2, 1'b0, 16'h0003, 5'h16}, 4'h0, 1'b1, 1'b0);
    expq.push_back(10'h303);
    drain("tag needed elsewhere");
    stall <= 1'b1;
    repeat (6)
    begin
      send({2'h0, 1'b1, 16'h0000, 5'h06}, 4'h6, 1'b0, 1'b0);
      put(48'ha1b2c3d4e5f6, 6, 1'b1);
    end
    repeat (10) @(posedge clk);
    check({reqReady, outValid}, 2'h1);
    // fifteen bursts went through unrefused, builder still busy, mix flag still sticky
    apb(1'b0, 8'h18, 32'h0);
    check(rd, 32'h000f0005);
    stall <= 1'b0;
    drain("fifo fill");
    give_verdict;
  end
  // the tests need a few hundred cycles; 20000 cycles marks a hang
  initial
  begin
    #500000;
    err_count++;
    give_verdict;
  end
endmodule

// File: tb/label_sink.sv
// byte sink standing for the gateway burst receiver
`timescale 1ns/1ps
module label_sink (
  input wire logic clk,
  input wire logic rst,
  input wire logic stall,
  input wire logic [15:0] defSvn,
  input wire logic outValid,
  input wire burst_label_pkg::labelByte_type outByte,
  output logic outReady,
  output logic [15:0] unitSvn
);
  burst_label_pkg::labelByte_type got[$];
  // ready lags the stall request by a cycle, as a slow receiver would
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      outReady <= 1'b0;
      unitSvn <= 16'h0000;
    end
    else
    begin
      outReady <= !stall;
      if (outValid && outReady)
      begin
        got.push_back(outByte);
        if (outByte.last)
          unitSvn <= outByte.alTag ? {8'h00, outByte.data} : defSvn;
      end
    end
  end
endmodule
